/* File: rtl/eic_pkg.sv */
`default_nettype none
package eic_pkg;

	// ----------------------------------------
	// register map (index selects the printed offset in REG_OFS, byte address = 4 * printed offset)
	// ----------------------------------------
	localparam int NREG = 27;
	localparam int IW   = 5;
	localparam int AW   = 18;

	localparam logic [IW-1:0] I_WM   = 5'h00;
	localparam logic [IW-1:0] I_PD   = 5'h01;
	localparam logic [IW-1:0] I_PA   = 5'h02;
	localparam logic [IW-1:0] I_PB   = 5'h03;
	localparam logic [IW-1:0] I_PC   = 5'h04;
	localparam logic [IW-1:0] I_STL  = 5'h05;
	localparam logic [IW-1:0] I_SH   = 5'h06;
	localparam logic [IW-1:0] I_SL   = 5'h07;
	localparam logic [IW-1:0] I_ENU  = 5'h0c;
	localparam logic [IW-1:0] I_STU  = 5'h0d;
	localparam logic [IW-1:0] I_SUH  = 5'h0e;
	localparam logic [IW-1:0] I_SUL  = 5'h0f;
	localparam logic [IW-1:0] I_PSU  = 5'h10;
	localparam logic [IW-1:0] I_PS   = 5'h11;
	localparam logic [IW-1:0] I_ENL  = 5'h12;
	localparam logic [IW-1:0] I_KM   = 5'h13;
	localparam logic [IW-1:0] I_KMA  = 5'h14;
	localparam logic [IW-1:0] I_SYS  = 5'h15;
	localparam logic [IW-1:0] I_SYS3 = 5'h16;
	localparam logic [IW-1:0] I_KBL  = 5'h17;
	localparam logic [IW-1:0] I_KBH  = 5'h18;
	localparam logic [IW-1:0] I_WKS  = 5'h19;
	localparam logic [IW-1:0] I_WSEL = 5'h1a;

	localparam logic [NREG-1:0][15:0] REG_OFS = {
		16'hfe75, 16'hfe74, 16'hfe73, 16'hfe72, 16'hfe71, 16'hfe70,
		16'hfff3, 16'hfff1, 16'hffc2, 16'hfefd, 16'hfefc, 16'hfefb,
		16'hfefa, 16'hfef9, 16'hfef8, 16'hfef7, 16'hfef6, 16'hfef5,
		16'hfef4, 16'hfeed, 16'hfeec, 16'hfeeb, 16'hfeea, 16'hfee9,
		16'hfee8, 16'hfe87, 16'hfe45};

	localparam logic [NREG-1:0][7:0] REG_RST = {
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08,
		8'hff, 8'hbf, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00};

	// status low/upper, keyboard low/high and wake status clear on a written one
	localparam logic [NREG-1:0] W1C_MASK = 27'h380_2020;

	// ----------------------------------------
	// fields
	// ----------------------------------------
	localparam int SYS_MODE_LO = 4;
	localparam int SYS_RESET_SOURCE_FLAG    = 3;
	localparam int SYS_NMI_EDGE_SELECT   = 2;
	localparam int SYS3_VMS    = 0;
	localparam logic [7:0] SYS_WMASK  = 8'h17;
	localparam logic [7:0] SYS3_WMASK = 8'h01;
	localparam int PRIO_KBL_BIT  = 0;
	localparam int PRIO_KBH_BIT  = 1;
	localparam int PRIO_WAKE_BIT = 0;

	localparam logic [1:0] SENSE_LOW  = 2'h0;
	localparam logic [1:0] SENSE_FALL = 2'h1;
	localparam logic [1:0] SENSE_RISE = 2'h2;
	localparam logic [1:0] SENSE_BOTH = 2'h3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic          awvalid;
		logic [AW-1:0] awaddr;
		logic          wvalid;
		logic [31:0]   wdata;
		logic [3:0]    wstrb;
		logic          bready;
		logic          arvalid;
		logic [AW-1:0] araddr;
		logic          rready;
	} axi_in_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_out_t;

endpackage : eic_pkg

`default_nettype wire

/* File: rtl/ext_irq_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module ext_irq_ctrl
	import eic_pkg::*;
(
	input  wire logic     core_clk_i,
	input  wire logic     rst_n_i,
	input  wire logic     ce_i,
	input  wire axi_in_t  axi_i,
	output var axi_out_t  axi_o,
	input  wire logic     nmi_pin_i,
	input  wire logic     nmi_ack_i,
	input  wire logic [15:0] irq_pins_i,
	input  wire logic [15:0] irq_alt_pins_i,
	input  wire logic [15:0] keyboard_input_pins_i,
	input  wire logic [7:0]  wake_event_pins_i,
	input  wire logic     wdt_reset_i,
	input  wire logic     cpu_mask_flag_i,
	input  wire logic     user_mask_flag_i,
	output logic          nmi_req_o,
	output logic          irq_o,
	output logic          irq_accept_o,
	output logic          irq_level_o,
	output logic          vector_mode_select_o,
	output logic          ctl_mode_sel_lo_o
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [NREG-1:0][7:0] regs;
		logic                 rst_cap;
		logic                 nmi_prev;
		logic                 nmi_pend;
		logic [15:0]          irq_prev;
		logic [15:0]          kin_prev;
		logic [7:0]           wake_prev;
		logic                 aw_have;
		logic                 w_have;
		logic [AW-1:0]        awaddr;
		logic [7:0]           wdata;
		logic                 wstb;
		logic                 irq;
		logic                 irq_acc;
		logic                 irq_lvl;
		axi_out_t             axo;
	} st_t;

	st_t q;
	st_t d;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	function automatic logic [IW:0] find(input logic [AW-1:0] a);
		logic [IW:0] r;
		r = '0;
		for (int k = 0; k < NREG; k++) begin
			if (a == {REG_OFS[k], 2'h0}) begin
				r = {1'b1, IW'(k)};
			end
		end
		return r;
	endfunction : find

	// ----------------------------------------
	// pin sensing
	// ----------------------------------------
	logic        vms;
	logic [7:0]  kmask_lo;
	logic [7:0]  kmask_hi;
	logic        kb_lo_act;
	logic        kb_hi_act;
	logic [31:0] sense_all;
	logic [15:0] psel_all;
	logic [15:0] pin_eff;
	logic [15:0] irq_hit;
	logic        nmi_hit;
	logic [15:0] kin_fall;
	logic [7:0]  wake_hit;

	assign vms       = q.regs[I_SYS3][SYS3_VMS];
	assign kmask_lo  = q.regs[I_KM];
	assign kmask_hi  = q.regs[I_KMA];
	assign sense_all = {q.regs[I_SUH], q.regs[I_SUL], q.regs[I_SH], q.regs[I_SL]};
	assign psel_all  = {q.regs[I_PSU], q.regs[I_PS]};

	assign kb_lo_act = ~vms & (|(~keyboard_input_pins_i[7:0] & ~kmask_lo));
	assign kb_hi_act = ~vms & (|(~keyboard_input_pins_i[15:8] & ~kmask_hi));

	for (genvar i = 0; i < 16; i++) begin : g_irq
		logic raw;
		logic gate;
		assign raw  = psel_all[i] ? irq_alt_pins_i[i] : irq_pins_i[i];
		assign gate = (i == 6) ? ~kb_lo_act : ((i == 7) ? ~kb_hi_act : 1'b1);
		// pins are active low, so a keyboard hit pulls the line low
		assign pin_eff[i] = raw & gate;

		always_comb begin
			unique case (sense_all[2*i +: 2])
				SENSE_LOW:  irq_hit[i] = ~pin_eff[i];
				SENSE_FALL: irq_hit[i] = q.irq_prev[i] & ~pin_eff[i];
				SENSE_RISE: irq_hit[i] = ~q.irq_prev[i] & pin_eff[i];
				SENSE_BOTH: irq_hit[i] = q.irq_prev[i] ^ pin_eff[i];
			endcase
		end
	end

	assign nmi_hit = q.regs[I_SYS][SYS_NMI_EDGE_SELECT] ? (~q.nmi_prev & nmi_pin_i)
	                                          : (q.nmi_prev & ~nmi_pin_i);

	assign kin_fall = q.kin_prev & ~keyboard_input_pins_i;

	assign wake_hit = (q.regs[I_WSEL] & ~q.wake_prev & wake_event_pins_i)
	                | (~q.regs[I_WSEL] & q.wake_prev & ~wake_event_pins_i);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic [IW:0]   wd;
		logic [IW:0]   rd;
		logic [IW-1:0] idx;
		logic [39:0]   pend;
		logic [39:0]   prio;
		logic          p0;
		logic          p1;
		wd   = find(q.awaddr);
		rd   = find(axi_i.araddr);
		idx  = wd[IW-1:0];
		pend = '0;
		prio = '0;
		p0   = 1'b0;
		p1   = 1'b0;
		d    = q;

		// catch reset cause once after release
		if (!q.rst_cap) begin
			d.rst_cap = 1'b1;
			d.regs[I_SYS][SYS_RESET_SOURCE_FLAG] = ~wdt_reset_i;
		end

		// write address and data, taken in either order
		if (q.axo.awready && axi_i.awvalid) begin
			d.aw_have = 1'b1;
			d.awaddr  = axi_i.awaddr;
		end
		if (q.axo.wready && axi_i.wvalid) begin
			d.w_have = 1'b1;
			d.wdata  = axi_i.wdata[7:0];
			d.wstb   = axi_i.wstrb[0];
		end
		if (q.axo.bvalid && axi_i.bready) begin
			d.axo.bvalid = 1'b0;
		end

		if (q.aw_have && q.w_have && !q.axo.bvalid) begin
			d.aw_have    = 1'b0;
			d.w_have     = 1'b0;
			d.axo.bvalid = 1'b1;
			d.axo.bresp  = wd[IW] ? RESP_OKAY : RESP_SLVERR;
			if (wd[IW] && q.wstb) begin
				if (W1C_MASK[idx]) begin
					d.regs[idx] = q.regs[idx] & ~q.wdata;
				end else if (idx == I_SYS) begin
					d.regs[idx] = (q.regs[idx] & ~SYS_WMASK) | (q.wdata & SYS_WMASK);
				end else if (idx == I_SYS3) begin
					d.regs[idx] = (q.regs[idx] & ~SYS3_WMASK) | (q.wdata & SYS3_WMASK);
				end else begin
					d.regs[idx] = q.wdata;
				end
			end
		end

		d.axo.awready = !d.aw_have && !d.axo.bvalid;
		d.axo.wready  = !d.w_have && !d.axo.bvalid;

		// read channel: one outstanding read
		if (q.axo.arready && axi_i.arvalid) begin
			d.axo.rvalid = 1'b1;
			d.axo.rresp  = rd[IW] ? RESP_OKAY : RESP_SLVERR;
			d.axo.rdata  = rd[IW] ? {24'h000000, q.regs[rd[IW-1:0]]} : 32'h00000000;
		end else if (q.axo.rvalid && axi_i.rready) begin
			d.axo.rvalid = 1'b0;
		end
		d.axo.arready = !d.axo.rvalid;

		if (nmi_hit) begin
			d.nmi_pend = 1'b1;
		end else if (nmi_ack_i) begin
			d.nmi_pend = 1'b0;
		end
		d.nmi_prev  = nmi_pin_i;
		d.irq_prev  = pin_eff;
		d.kin_prev  = keyboard_input_pins_i;
		d.wake_prev = wake_event_pins_i;

		// sticky set after clear, so a set wins
		d.regs[I_STL] = d.regs[I_STL] | (irq_hit[7:0] & q.regs[I_ENL]);
		d.regs[I_STU] = d.regs[I_STU] | (irq_hit[15:8] & q.regs[I_ENU]);
		// keyboard flags only in extended mode
		if (vms) begin
			d.regs[I_KBL] = d.regs[I_KBL] | (kin_fall[7:0] & ~kmask_lo);
			d.regs[I_KBH] = d.regs[I_KBH] | (kin_fall[15:8] & ~kmask_hi);
		end
		d.regs[I_WKS] = d.regs[I_WKS] | (wake_hit & ~q.regs[I_WM]);

		// pending sources, gated by their enables or masks
		pend[15:0]  = {d.regs[I_STU], d.regs[I_STL]} & {d.regs[I_ENU], d.regs[I_ENL]};
		pend[31:16] = {d.regs[I_KBH], d.regs[I_KBL]} & ~{d.regs[I_KMA], d.regs[I_KM]};
		pend[39:32] = d.regs[I_WKS] & ~d.regs[I_WM];

		prio = {{8{d.regs[I_PD][PRIO_WAKE_BIT]}},
		        {8{d.regs[I_PC][PRIO_KBH_BIT]}},
		        {8{d.regs[I_PC][PRIO_KBL_BIT]}},
		        d.regs[I_PB],
		        d.regs[I_PA]};
		p1 = |(pend & prio);
		p0 = |(pend & ~prio);

		d.irq     = |pend;
		d.irq_lvl = p1;

		// mode 1 keeps level-1 open until both masks set
		if (d.regs[I_SYS][SYS_MODE_LO]) begin
			d.irq_acc = (p1 && !(cpu_mask_flag_i && user_mask_flag_i))
			         || (p0 && !cpu_mask_flag_i);
		end else begin
			d.irq_acc = (p0 || p1) && !cpu_mask_flag_i;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q           <= '0;
			q.regs      <= REG_RST;
			q.nmi_prev  <= 1'b1;
			q.irq_prev  <= 16'hffff;
			q.kin_prev  <= 16'hffff;
			q.wake_prev <= 8'hff;
		end else if (ce_i) begin
			q <= d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign axi_o        = q.axo;
	assign nmi_req_o    = q.nmi_pend;
	assign irq_o        = q.irq;
	assign irq_accept_o = q.irq_acc;
	assign irq_level_o  = q.irq_lvl;
	// layout choice to the vector logic
	assign vector_mode_select_o = q.regs[I_SYS3][SYS3_VMS];
	assign ctl_mode_sel_lo_o    = q.regs[I_SYS][SYS_MODE_LO];

endmodule : ext_irq_ctrl

`default_nettype wire

/* File: verif/ext_irq_ctrl_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_irq_ctrl_checker
	import eic_pkg::*;
(
	input wire logic     core_clk_i,
	input wire logic     rst_n_i,
	input wire logic     ce_i,
	input wire axi_in_t  axi_i,
	input wire axi_out_t axi_o,
	input wire logic     nmi_pin_i,
	input wire logic     nmi_ack_i,
	input wire logic     cpu_mask_flag_i,
	input wire logic     user_mask_flag_i,
	input wire logic     nmi_req_o,
	input wire logic     irq_accept_o,
	input wire logic     ctl_mode_sel_lo_o
);
	localparam logic [AW-1:0] SYS_ADDR = {REG_OFS[I_SYS], 2'b00};
	logic [AW-1:0] rd_addr_q;

	// address of the read in flight
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) rd_addr_q <= '0;
		else if (ce_i && axi_i.arvalid && axi_o.arready) rd_addr_q <= axi_i.araddr;
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_WR_RESP: assert property (ce_i && axi_i.awvalid && axi_o.awready && axi_i.wvalid
		&& axi_o.wready |-> ##2 axi_o.bvalid) else $error("write answer late");
	AST_RD_RESP: assert property (ce_i && axi_i.arvalid && axi_o.arready |=> axi_o.rvalid)
		else $error("read answer late");
	AST_B_HOLD: assert property (axi_o.bvalid && !axi_i.bready |=> axi_o.bvalid
		&& $stable(axi_o.bresp)) else $error("write answer dropped");
	AST_R_HOLD: assert property (axi_o.rvalid && !axi_i.rready |=> axi_o.rvalid
		&& $stable(axi_o.rdata)) else $error("read answer dropped");
	AST_SYS_RSVD: assert property (axi_o.rvalid && rd_addr_q == SYS_ADDR |->
		axi_o.rdata[7:5] == 3'h0) else $error("reserved control bits set");
	AST_NMI_EDGE: assert property ($rose(nmi_req_o) |->
		$past(nmi_pin_i) != $past(nmi_pin_i, 2)) else $error("nmi without edge");
	AST_NMI_HOLD: assert property (nmi_req_o && !nmi_ack_i |=> nmi_req_o)
		else $error("nmi lost");
	AST_NMI_ACK: assert property (ce_i && nmi_req_o && nmi_ack_i && $stable(nmi_pin_i)
		&& $past(nmi_pin_i) == $past(nmi_pin_i, 2) |=> !nmi_req_o) else $error("nmi kept");
	AST_MASK: assert property ($past(cpu_mask_flag_i) && (!ctl_mode_sel_lo_o
		|| $past(user_mask_flag_i)) |-> !irq_accept_o) else $error("masked irq taken");
endmodule : ext_irq_ctrl_checker

bind ext_irq_ctrl ext_irq_ctrl_checker u_ext_irq_ctrl_checker (
	.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .axi_i(axi_i), .axi_o(axi_o),
	.nmi_pin_i(nmi_pin_i), .nmi_ack_i(nmi_ack_i), .cpu_mask_flag_i(cpu_mask_flag_i),
	.user_mask_flag_i(user_mask_flag_i), .nmi_req_o(nmi_req_o),
	.irq_accept_o(irq_accept_o), .ctl_mode_sel_lo_o(ctl_mode_sel_lo_o));
`default_nettype wire

/* File: verif/far_end.sv */
`timescale 1ns/1ps
`default_nettype none
module far_end #(
	parameter int ACK_DLY = 2
) (
	input  wire logic   core_clk_i,
	input  wire logic   nmi_req_i,
	output logic        nmi_ack_o,
	output logic        nmi_pin_o,
	output logic [15:0] irq_pins_o,
	output logic [15:0] kbd_pins_o,
	output logic [7:0]  wake_pins_o,
	output logic        cpu_mask_o,
	output logic        user_mask_o
);
	int cnt;
	// pins idle high, the bench moves them
	initial begin
		{nmi_pin_o, irq_pins_o, kbd_pins_o, wake_pins_o} = '1;
		{nmi_ack_o, cpu_mask_o, user_mask_o} = '0;
		cnt = 0;
	end
	always @(posedge core_clk_i) begin
		if (nmi_req_i && !nmi_ack_o && cnt < ACK_DLY) cnt <= cnt + 1;
		else cnt <= 0;
		nmi_ack_o <= nmi_req_i && !nmi_ack_o && cnt == ACK_DLY;
	end
endmodule : far_end
`default_nettype wire

/* File: verif/test_ext_irq_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module test_ext_irq_ctrl
	import eic_pkg::*;
;
	localparam logic [3:0] FALL_HIT = 4'b1011;
	localparam logic [3:0] RISE_HIT = 4'b1101;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wdt = 1'b0;
	logic ce = 1'b1;
	axi_in_t ai = '0;
	axi_out_t ao;
	logic nmi_pin, nmi_ack, cm, um, nmi_req, irq, acc, lvl, vms, mlo;
	logic [15:0] ip, kp;
	logic [7:0] wp, d;
	logic [1:0] rs;
	int bad_count = 0;
	int compares = 0;
	int cyc = 0;
	always #2 clk = ~clk;

	ext_irq_ctrl u_ext_irq_ctrl (.core_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .axi_i(ai),
		.axi_o(ao), .nmi_pin_i(nmi_pin), .nmi_ack_i(nmi_ack), .irq_pins_i(ip),
		.irq_alt_pins_i(16'hffff), .keyboard_input_pins_i(kp), .wake_event_pins_i(wp),
		.wdt_reset_i(wdt), .cpu_mask_flag_i(cm), .user_mask_flag_i(um), .nmi_req_o(nmi_req),
		.irq_o(irq), .irq_accept_o(acc), .irq_level_o(lvl), .vector_mode_select_o(vms),
		.ctl_mode_sel_lo_o(mlo));
	far_end #(.ACK_DLY(4)) u_far_end (.core_clk_i(clk), .nmi_req_i(nmi_req),
		.nmi_ack_o(nmi_ack), .nmi_pin_o(nmi_pin), .irq_pins_o(ip), .kbd_pins_o(kp),
		.wake_pins_o(wp), .cpu_mask_o(cm), .user_mask_o(um));

	function automatic logic [AW-1:0] ad(input logic [IW-1:0] i);
		return {REG_OFS[i], 2'b00};
	endfunction : ad
	// answer ready raised with the request, dropped at the edge the answer is seen
	task automatic wr(input logic [AW-1:0] a, input logic [7:0] v);
		@(posedge clk);
		ai.awaddr <= a;
		ai.wdata <= {24'h0, v};
		ai.wstrb <= 4'hf;
		ai.awvalid <= 1'b1;
		ai.wvalid <= 1'b1;
		ai.bready <= 1'b1;
		do begin
			@(posedge clk);
			if (ao.awready) ai.awvalid <= 1'b0;
			if (ao.wready) ai.wvalid <= 1'b0;
		end while (!ao.bvalid);
		rs = ao.bresp;
		ai.bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [AW-1:0] a);
		@(posedge clk);
		ai.araddr <= a;
		ai.arvalid <= 1'b1;
		ai.rready <= 1'b1;
		do begin
			@(posedge clk);
			if (ao.arready) ai.arvalid <= 1'b0;
		end while (!ao.rvalid);
		d = ao.rdata[7:0];
		rs = ao.rresp;
		ai.rready <= 1'b0;
	endtask : rd
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t value %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chkb(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask : chkb
	task automatic mask_chk(input logic i_f, input logic u_f, input logic exp);
		u_far_end.cpu_mask_o <= i_f;
		u_far_end.user_mask_o <= u_f;
		repeat (3) @(posedge clk);
		chkb(acc, exp);
	endtask : mask_chk
	task automatic nmi_chk(input logic pin, input logic exp);
		u_far_end.nmi_pin_o <= pin;
		repeat (4) @(posedge clk);
		chkb(nmi_req, exp);
		repeat (10) @(posedge clk);
		chkb(nmi_req, 1'b0);
	endtask : nmi_chk
	task automatic print_verdict();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			$display("[ERR] %0t timeout", $time);
			print_verdict();
		end
	end

	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < NREG; i++) begin
			rd(ad(i[IW-1:0]));
			chk(d, REG_RST[i]);
		end
		wr(ad(I_SYS), 8'hff);
		rd(ad(I_SYS));
		chk(d, 8'h1f);
		rd(18'h0);
		chk({6'h0, rs}, {6'h0, RESP_SLVERR});
		wr(ad(I_SYS), 8'h08);
		$display("register test done");
		wr(ad(I_ENL), 8'h01);
		wr(ad(I_STL), 8'hff);
		rd(ad(I_STL));
		chk(d, 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr(ad(I_SL), {6'h0, SENSE_FALL});
			wr(ad(I_STL), 8'h01);
			wr(ad(I_SL), {6'h0, c[1:0]});
			u_far_end.irq_pins_o[0] <= 1'b0;
			repeat (4) @(posedge clk);
			rd(ad(I_STL));
			chk(d, {7'h0, FALL_HIT[c]});
			chkb(irq, FALL_HIT[c]);
			wr(ad(I_SL), {6'h0, SENSE_RISE});
			wr(ad(I_STL), 8'h01);
			wr(ad(I_SL), {6'h0, c[1:0]});
			u_far_end.irq_pins_o[0] <= 1'b1;
			repeat (4) @(posedge clk);
			rd(ad(I_STL));
			chk(d, {7'h0, RISE_HIT[c]});
		end
		$display("sense test done");
		mask_chk(1'b1, 1'b0, 1'b0);
		mask_chk(1'b0, 1'b0, 1'b1);
		wr(ad(I_SYS), 8'h10);
		chkb(mlo, 1'b1);
		wr(ad(I_PA), 8'h01);
		mask_chk(1'b1, 1'b0, 1'b1);
		chkb(lvl, 1'b1);
		mask_chk(1'b1, 1'b1, 1'b0);
		wr(ad(I_PA), 8'h00);
		mask_chk(1'b1, 1'b0, 1'b0);
		wr(ad(I_SYS), 8'h00);
		nmi_chk(1'b0, 1'b1);
		nmi_chk(1'b1, 1'b0);
		wr(ad(I_SYS), 8'h04);
		nmi_chk(1'b0, 1'b0);
		nmi_chk(1'b1, 1'b1);
		$display("mask and nmi test done");
		wr(ad(I_SYS3), 8'h01);
		chkb(vms, 1'b1);
		wr(ad(I_KM), 8'hbe);
		u_far_end.kbd_pins_o[0] <= 1'b0;
		repeat (4) @(posedge clk);
		rd(ad(I_KBL));
		chk(d, 8'h01);
		u_far_end.kbd_pins_o[0] <= 1'b1;
		wr(ad(I_SYS3), 8'h00);
		wr(ad(I_ENL), 8'h40);
		wr(ad(I_SH), 8'h10);
		wr(ad(I_STL), 8'hff);
		u_far_end.kbd_pins_o[0] <= 1'b0;
		repeat (4) @(posedge clk);
		rd(ad(I_STL));
		chk(d, 8'h40);
		u_far_end.wake_pins_o[0] <= 1'b0;
		wr(ad(I_WSEL), 8'h01);
		wr(ad(I_WKS), 8'h01);
		u_far_end.wake_pins_o[0] <= 1'b1;
		repeat (4) @(posedge clk);
		rd(ad(I_WKS));
		chk(d, 8'h01);
		$display("keyboard and wake test done");
		// rising nmi edge while frozen must leave no request behind
		ce <= 1'b0;
		u_far_end.nmi_pin_o <= 1'b0;
		repeat (2) @(posedge clk);
		u_far_end.nmi_pin_o <= 1'b1;
		repeat (2) @(posedge clk);
		ce <= 1'b1;
		repeat (4) @(posedge clk);
		chkb(nmi_req, 1'b0);
		$display("clock enable test done");
		wdt <= 1'b1;
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		wdt <= 1'b0;
		rd(ad(I_SYS));
		chk(d, 8'h00);
		$display("watchdog reset test done");
		print_verdict();
	end
endmodule : test_ext_irq_ctrl
`default_nettype wire
